// File: hdl/cpf_pkg.sv
package cpf_pkg;

  // bus geometry
  localparam int unsigned CPF_ADDR_W = 12;
  localparam int unsigned CPF_DATA_W = 32;
  localparam int unsigned CPF_REG_W = 8;

  // register byte offsets
  localparam logic [11:0] CPF_PIN_CTRL_OFS = 12'h000;
  localparam logic [11:0] CPF_EVENT_FLAGS_OFS = 12'h004;
  localparam logic [11:0] CPF_EVENT_MASK_OFS = 12'h008;
  localparam logic [11:0] CPF_PIN_STATE_OFS = 12'h00C;

  // pin control field positions
  localparam int unsigned CPF_DRIVE_HIGH_BIT = 5;
  localparam int unsigned CPF_CAPTURE_SEL_BIT = 4;

  // event flag field positions
  localparam int unsigned CPF_RXB0_BIT = 0;
  localparam int unsigned CPF_RXB1_BIT = 1;
  localparam int unsigned CPF_TXB0_BIT = 2;
  localparam int unsigned CPF_TXB1_BIT = 3;
  localparam int unsigned CPF_TXB2_BIT = 4;
  localparam int unsigned CPF_ERR_BIT = 5;
  localparam int unsigned CPF_WAKE_BIT = 6;
  localparam int unsigned CPF_INVALID_BIT = 7;

  // pin state field positions
  localparam int unsigned CPF_STATE_RX_BIT = 0;
  localparam int unsigned CPF_STATE_PORT_BIT = 1;
  localparam int unsigned CPF_STATE_TX_BIT = 2;
  localparam int unsigned CPF_STATE_OE_N_BIT = 3;

  // reset values and writable masks
  localparam logic [7:0] CPF_PIN_CTRL_RST = 8'h00;
  localparam logic [7:0] CPF_PIN_CTRL_WMASK = 8'h30;
  localparam logic [7:0] CPF_EVENT_FLAGS_RST = 8'h00;
  localparam logic [7:0] CPF_EVENT_MASK_RST = 8'h00;
  // idle pin pair: receive line recessive high, port pin low
  localparam logic [1:0] CPF_PIN_PAIR_RST = 2'h2;

  // one apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cpf_apb_req_s;

  // event flags, packed in register bit order (bit 7 first)
  typedef struct packed {
    logic invalid_message_flag;
    logic bus_activity_wake_flag;
    logic bus_error_flag;
    logic tx_buffer2_empty_flag;
    logic tx_buffer1_empty_flag;
    logic tx_buffer0_empty_flag;
    logic rx_buffer1_full_flag;
    logic rx_buffer0_full_flag;
  } cpf_evt_s;

  // pin inputs arriving from outside the clock domain
  typedef struct packed {
    logic can_receive_pin;
    logic port_c_pin_two;
  } cpf_pin_pair_s;

endpackage

// File: hdl/cpf_pin_sync.sv
`timescale 1ns/1ps

// two flip-flop synchroniser for the incoming pins
module cpf_pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire cpf_pkg::cpf_pin_pair_s pins_async,
  output cpf_pkg::cpf_pin_pair_s pins_sync
);
  import cpf_pkg::*;

  typedef struct packed {
    cpf_pin_pair_s stage1;
    cpf_pin_pair_s stage2;
  } cpf_sync_state_s;

  cpf_sync_state_s state_reg;
  cpf_sync_state_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.stage1 = pins_async;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{stage1: CPF_PIN_PAIR_RST, stage2: CPF_PIN_PAIR_RST};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pins_sync = state_reg.stage2;

endmodule

// File: hdl/cpf_tx_drive.sv
`timescale 1ns/1ps

// transmit pin driver: dominant drives low, recessive per drive-high enable
module cpf_tx_drive (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_bit,
  input wire logic drive_high_enable,
  output logic pin_level,
  output logic pin_oe_n
);
  import cpf_pkg::*;

  typedef struct packed {
    logic level;
    logic oe_n;
  } cpf_drive_state_s;

  cpf_drive_state_s state_reg;
  cpf_drive_state_s state_next;

  always_comb begin
    state_next = state_reg;
    if (!tx_bit) begin
      state_next.level = 1'b0;
      state_next.oe_n = 1'b0;
    end else if (drive_high_enable) begin
      state_next.level = 1'b1;
      state_next.oe_n = 1'b0;
    end else begin
      state_next.level = 1'b1;
      state_next.oe_n = 1'b1;
    end
  end

  // released pin out of reset: recessive, not driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{level: 1'b1, oe_n: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_level = state_reg.level;
  assign pin_oe_n = state_reg.oe_n;

endmodule

// File: hdl/cpf_can_pin_ctrl.sv
`timescale 1ns/1ps

module cpf_can_pin_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire cpf_pkg::cpf_apb_req_s apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire cpf_pkg::cpf_evt_s evt_set,
  input wire logic tx_bit,
  input wire cpf_pkg::cpf_pin_pair_s pins_async,
  output logic can_transmit_pin_level,
  output logic can_transmit_pin_oe_n,
  output logic can_receive_level,
  output logic capture_compare_unit_one_src,
  output logic irq
);
  import cpf_pkg::*;

  typedef struct packed {
    logic [7:0] pin_ctrl;
    cpf_evt_s flags;
    logic [7:0] mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic capture_src;
    logic rx_level;
  } cpf_top_state_s;

  cpf_top_state_s state_reg;
  cpf_top_state_s state_next;

  cpf_pin_pair_s pins_sync;
  logic drive_high_enable;
  logic capture_select;
  logic tx_level;
  logic tx_oe_n;

  // apb phase decode
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic addr_hit;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] flags_after;
  logic [7:0] pin_state;

  cpf_pin_sync u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins_async(pins_async),
    .pins_sync(pins_sync)
  );

  assign drive_high_enable = state_reg.pin_ctrl[CPF_DRIVE_HIGH_BIT];
  assign capture_select = state_reg.pin_ctrl[CPF_CAPTURE_SEL_BIT];

  cpf_tx_drive u_tx_drive (
    .pclk(pclk),
    .presetn(presetn),
    .tx_bit(tx_bit),
    .drive_high_enable(drive_high_enable),
    .pin_level(tx_level),
    .pin_oe_n(tx_oe_n)
  );

  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign access_done = apb_req.psel && apb_req.penable && state_reg.pready;
  assign wr_done = access_done && apb_req.pwrite && !state_reg.pslverr;
  assign wr_byte = apb_req.pwdata[7:0];

  // address decode
  always_comb begin
    addr_hit = 1'b1;
    case (apb_req.paddr)
      CPF_PIN_CTRL_OFS: begin
        addr_hit = 1'b1;
      end
      CPF_EVENT_FLAGS_OFS: begin
        addr_hit = 1'b1;
      end
      CPF_EVENT_MASK_OFS: begin
        addr_hit = 1'b1;
      end
      CPF_PIN_STATE_OFS: begin
        addr_hit = 1'b1;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // live view of the pins
  always_comb begin
    pin_state = 8'h00;
    pin_state[CPF_STATE_RX_BIT] = pins_sync.can_receive_pin;
    pin_state[CPF_STATE_PORT_BIT] = pins_sync.port_c_pin_two;
    pin_state[CPF_STATE_TX_BIT] = tx_level;
    pin_state[CPF_STATE_OE_N_BIT] = tx_oe_n;
  end

  // read mux, sampled in the setup phase
  always_comb begin
    rd_byte = 8'h00;
    case (apb_req.paddr)
      CPF_PIN_CTRL_OFS: begin
        rd_byte = state_reg.pin_ctrl & CPF_PIN_CTRL_WMASK;
      end
      CPF_EVENT_FLAGS_OFS: begin
        rd_byte = state_reg.flags;
      end
      CPF_EVENT_MASK_OFS: begin
        rd_byte = state_reg.mask;
      end
      CPF_PIN_STATE_OFS: begin
        rd_byte = pin_state;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // event flags: hardware set wins over a write-one clear in the same cycle
  always_comb begin
    flag_set = evt_set;
    flag_clr = 8'h00;
    if (wr_done && apb_req.paddr == CPF_EVENT_FLAGS_OFS) begin
      flag_clr = wr_byte;
    end
    flags_after = (state_reg.flags & ~flag_clr) | flag_set;
  end

  always_comb begin
    state_next = state_reg;

    // apb answer: one access cycle, zero wait
    state_next.pready = setup_phase;
    if (setup_phase) begin
      state_next.pslverr = !addr_hit;
      state_next.prdata = {24'h000000, rd_byte};
    end else begin
      state_next.pslverr = 1'b0;
      state_next.prdata = 32'h00000000;
    end

    // register writes
    if (wr_done) begin
      case (apb_req.paddr)
        CPF_PIN_CTRL_OFS: begin
          state_next.pin_ctrl = wr_byte & CPF_PIN_CTRL_WMASK;
        end
        CPF_EVENT_MASK_OFS: begin
          state_next.mask = wr_byte;
        end
        default: begin
          state_next.pin_ctrl = state_reg.pin_ctrl;
        end
      endcase
    end

    state_next.flags = flags_after;

    // level interrupt from unmasked flags
    state_next.irq = |(flags_after & state_next.mask);

    // capture source routing
    if (capture_select) begin
      state_next.capture_src = pins_sync.can_receive_pin;
    end else begin
      state_next.capture_src = pins_sync.port_c_pin_two;
    end

    state_next.rx_level = pins_sync.can_receive_pin;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.pin_ctrl <= CPF_PIN_CTRL_RST;
      state_reg.flags <= CPF_EVENT_FLAGS_RST;
      state_reg.mask <= CPF_EVENT_MASK_RST;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.prdata <= 32'h00000000;
      state_reg.irq <= 1'b0;
      state_reg.capture_src <= 1'b0;
      state_reg.rx_level <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pready = state_reg.pready;
  assign prdata = state_reg.prdata;
  assign pslverr = state_reg.pslverr;
  assign irq = state_reg.irq;
  assign capture_compare_unit_one_src = state_reg.capture_src;
  assign can_receive_level = state_reg.rx_level;
  assign can_transmit_pin_level = tx_level;
  assign can_transmit_pin_oe_n = tx_oe_n;

endmodule

// File: bench/cpf_can_xcvr.sv
`timescale 1ns/1ps
module cpf_can_xcvr (
  input wire logic tx_level,
  input wire logic tx_oe_n,
  input wire logic other_dominant,
  output logic rx_pin
);
  // bus idles recessive through termination, any dominant wins
  assign rx_pin = !((!tx_oe_n && !tx_level) || other_dominant);
endmodule

// File: bench/cpf_monitor.sv
`timescale 1ns/1ps
module cpf_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire cpf_pkg::cpf_apb_req_s apb_req,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire cpf_pkg::cpf_evt_s evt_set,
  input wire logic tx_bit,
  input wire cpf_pkg::cpf_pin_pair_s pins_async,
  input wire logic can_transmit_pin_level,
  input wire logic can_transmit_pin_oe_n,
  input wire logic can_receive_level,
  input wire logic capture_compare_unit_one_src,
  input wire logic irq
);
  import cpf_pkg::*;
  logic en_reg, sel_reg, wr, cause;
  logic [1:0] cnt_reg;
  assign wr = pready && apb_req.pwrite && !pslverr
    && apb_req.paddr == CPF_PIN_CTRL_OFS;
  assign cause = evt_set != 8'h00 || (pready && apb_req.pwrite);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 1'b0;
      sel_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (wr) begin
        en_reg <= apb_req.pwdata[CPF_DRIVE_HIGH_BIT];
        sel_reg <= apb_req.pwdata[CPF_CAPTURE_SEL_BIT];
      end
      if (cnt_reg != 2'h3) begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable
    |=> pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (apb_req.psel && !apb_req.penable
    && apb_req.paddr > CPF_PIN_STATE_OFS |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_tx_dominant: assert property (!tx_bit |=> !can_transmit_pin_level
    && !can_transmit_pin_oe_n) else $error("dominant not driven low");
  a_tx_drive_high: assert property (tx_bit && en_reg |=>
    can_transmit_pin_level && !can_transmit_pin_oe_n)
    else $error("recessive not driven high");
  a_tx_float: assert property (tx_bit && !en_reg |=>
    can_transmit_pin_oe_n) else $error("recessive not released");
  a_irq_cause: assert property ($rose(irq) |-> $past(cause))
    else $error("irq rose without event");
  a_irq_sticky: assert property (irq && !(pready && apb_req.pwrite)
    |=> irq) else $error("irq dropped without write");
  a_cap_receive: assert property (cnt_reg == 2'h3 && sel_reg
    && $past(sel_reg) |-> capture_compare_unit_one_src
    == $past(pins_async.can_receive_pin, 3)) else $error("capture not rx");
  a_cap_port: assert property (cnt_reg == 2'h3 && !sel_reg
    && !$past(sel_reg) |-> capture_compare_unit_one_src
    == $past(pins_async.port_c_pin_two, 3)) else $error("capture not port");
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cpf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  cpf_apb_req_s apb_req = '0;
  cpf_evt_s evt_set = '0;
  cpf_pin_pair_s pins;
  logic tx_bit = 1'b1;
  logic port_pin = 1'b0;
  logic other_dom = 1'b0;
  logic rx_pin, pready, pslverr, tx_level, tx_oe_n, rx_level, cap_src, irq;
  logic [31:0] prdata;
  logic [33:0] exp_q[$];
  logic [33:0] mon_e;
  int err_total = 0;
  int n_compared = 0;
  int seed = 15;
  assign pins = {rx_pin, port_pin};
  initial forever #50 pclk = ~pclk;
  cpf_can_pin_ctrl dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .evt_set(evt_set),
    .tx_bit(tx_bit), .pins_async(pins), .can_transmit_pin_level(tx_level),
    .can_transmit_pin_oe_n(tx_oe_n), .can_receive_level(rx_level),
    .capture_compare_unit_one_src(cap_src), .irq(irq));
  cpf_can_xcvr xcvr (.tx_level(tx_level), .tx_oe_n(tx_oe_n),
    .other_dominant(other_dom), .rx_pin(rx_pin));
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic [32:0] e);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
      pwdata: {24'h0, d}};
    exp_q.push_back({~w, e});
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d);
    apb(1'b0, a, 8'h00, {25'h0, d});
  endtask
  task automatic drive(input logic t, input logic en);
    @(posedge pclk);
    tx_bit <= t;
    repeat (2) @(posedge pclk);
    chk({31'h0, tx_oe_n, tx_oe_n ? 1'b0 : tx_level},
      {31'h0, t & ~en, (t & ~en) ? 1'b0 : t});
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1 && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      if (mon_e[33]) begin
        chk({pslverr, prdata}, mon_e[32:0]);
      end else begin
        chk({32'h0, pslverr}, {32'h0, mon_e[32]});
      end
    end
  end
  initial begin
    #(3000 * 100);
    err_total++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(CPF_PIN_CTRL_OFS, 8'h00);
    rd(CPF_EVENT_FLAGS_OFS, 8'h00);
    apb(1'b0, 12'h010, 8'h00, {1'b1, 32'h0});
    apb(1'b1, CPF_PIN_CTRL_OFS, 8'hFF, 33'h0);
    rd(CPF_PIN_CTRL_OFS, 8'h30);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CPF_PIN_CTRL_OFS, {2'b00, i[1], 5'h00}, 33'h0);
      drive(i[0], i[1]);
    end
    $display("test transmit done");
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, CPF_EVENT_MASK_OFS, (i < 8) ? 8'hFF : 8'h00, 33'h0);
      @(posedge pclk);
      evt_set <= 8'(1 << (i % 8));
      @(posedge pclk);
      evt_set <= '0;
      repeat (2) @(posedge pclk);
      chk({32'h0, irq}, {32'h0, i < 8});
      rd(CPF_EVENT_FLAGS_OFS, 8'(1 << (i % 8)));
      rd(CPF_EVENT_MASK_OFS, (i < 8) ? 8'hFF : 8'h00);
      apb(1'b1, CPF_EVENT_FLAGS_OFS, 8'(1 << (i % 8)), 33'h0);
      rd(CPF_EVENT_FLAGS_OFS, 8'h00);
    end
    $display("test events done");
    for (int i = 0; i < 16; i++) begin
      if (i % 8 == 0) begin
        apb(1'b1, CPF_PIN_CTRL_OFS, (i < 8) ? 8'h10 : 8'h20, 33'h0);
      end
      @(posedge pclk);
      {port_pin, other_dom, tx_bit} <= 3'($random(seed));
      repeat (5) @(posedge pclk);
      chk({31'h0, cap_src, rx_level},
        {31'h0, (i < 8) ? rx_pin : port_pin, rx_pin});
      rd(CPF_PIN_STATE_OFS,
        {4'h0, (i < 8) && tx_bit, tx_bit, port_pin, rx_pin});
    end
    $display("test capture done");
    final_report();
  end
endmodule
bind cpf_can_pin_ctrl cpf_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .evt_set(evt_set), .tx_bit(tx_bit), .pins_async(pins_async),
  .can_transmit_pin_level(can_transmit_pin_level),
  .can_transmit_pin_oe_n(can_transmit_pin_oe_n),
  .can_receive_level(can_receive_level),
  .capture_compare_unit_one_src(capture_compare_unit_one_src), .irq(irq));
